/* rtl/spis_pkg.sv */
package spis_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENA_SET = 8'h08;
  localparam logic [7:0] OFS_ENA_CLR = 8'h0c;
  localparam logic [7:0] OFS_ENA_VIEW = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // control command bit positions in the control register
  localparam int CMD_CLR_ERR_BIT = 8;
  localparam int CMD_CLR_NON_ACK_FLAG_BIT = 14;
  // status / mask bit positions
  localparam int B_RX_CHAR_AVAILABLE = 0;
  localparam int B_TX_HOLDING_FREE = 1;
  localparam int B_BRK = 2;
  localparam int B_RX_TRANSFER_END = 3;
  localparam int B_TX_TRANSFER_END = 4;
  localparam int B_OVR = 5;
  localparam int B_FRM = 6;
  localparam int B_PAR = 7;
  localparam int B_TMO = 8;
  localparam int B_TXEMP = 9;
  localparam int B_ITER = 10;
  localparam int B_TXBE = 11;
  localparam int B_RXBF = 12;
  localparam int B_NON_ACK_FLAG = 13;
  localparam int B_CTS_CHANGE_FLAG = 19;
  localparam int B_MANLO = 20;
  localparam int B_CTS = 23;
  localparam int B_MAN = 24;
  // writable mask bits and flag bits
  localparam logic [31:0] MASK_BITS = 32'h0118_3fff;
  localparam logic [31:0] ENA_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
endpackage : spis_pkg

/* rtl/spis_irq_status.sv */
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Functional notes
// [R01] write-only enable register at 0x8, bit n enables source n
// [R02] write-only disable register at 0xC, bit n disables source n
// [R03] read-only mask view at 0x10, zero after reset
// [R04] read-only flag register at 0x14, bits 0..13 share mask positions
// [R05] bits 0..4: rx ready, tx ready, break, rx end, tx end
// [R06] bits 5..9: overrun, framing, parity, timeout, tx empty
// [R07] bits 11..13: tx buffer empty, rx buffer full, non_ack_flag; others unused
// [R08] bit 10 is iteration reached, or underrun in spi slave mode
// [R09] mask bit 19 is cts change; manchester enables at 20 and 24
// [R10] flag 24 sets on manchester error, held until clear-errors command
// [R11] flag 23 shows the present cts pin level
// [R12] flag 19 sets on cts change, cleared by reading flag register
// [R13] flag 13 sets on non_ack_flag, held until clear-non_ack_flag command
// [R14] clear-errors clears parity, framing, overrun, manchester, break and iteration together
// [R15] overrun, parity and framing flags are sticky until clear-errors
// [R16] writing 1 to enable sets mask bit, to disable clears it
// [R17] interrupt high while any flag is set with its mask bit set
module spis_irq_status (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // live levels from the datapath, same clock
  input wire logic rx_char_available_i,
  input wire logic tx_holding_free_i,
  input wire logic rx_transfer_end_i,
  input wire logic tx_transfer_end_i,
  input wire logic rx_timeout_i,
  input wire logic tx_all_drained_i,
  input wire logic tx_dma_buffer_empty_i,
  input wire logic rx_dma_buffer_full_i,
  // one-cycle error events from the datapath, same clock
  input wire logic break_evt_i,
  input wire logic overrun_evt_i,
  input wire logic framing_evt_i,
  input wire logic parity_evt_i,
  input wire logic iter_or_underrun_evt_i,
  input wire logic non_ack_evt_i,
  input wire logic manchester_evt_i,
  // pin from outside
  input wire logic cts_pin_i,
  // interrupt
  output logic irq_o
);

  typedef struct packed {
    logic [31:0] ena;
    logic [31:0] flg;
    logic cts_s1;
    logic cts_s2;
    logic cts_d;
    logic [31:0] rdata;
    logic irq;
  } spis_state_t;

  spis_state_t st_r;
  spis_state_t st_nxt;
  logic [31:0] live_w;
  logic [31:0] view_w;
  logic clr_err_w;
  logic clr_non_ack_flag_w;
  logic rd_flags_w;

  // command and read decode
  assign clr_err_w = reg_wr_i && reg_addr_i == spis_pkg::OFS_CTRL
    && reg_wdata_i[spis_pkg::CMD_CLR_ERR_BIT];
  assign clr_non_ack_flag_w = reg_wr_i && reg_addr_i == spis_pkg::OFS_CTRL
    && reg_wdata_i[spis_pkg::CMD_CLR_NON_ACK_FLAG_BIT];
  assign rd_flags_w = reg_rd_i && reg_addr_i == spis_pkg::OFS_FLAGS;

  // live level bits folded into the flag view
  always_comb begin
    live_w = 32'h0;
    live_w[spis_pkg::B_RX_CHAR_AVAILABLE] = rx_char_available_i; // see [R05]
    live_w[spis_pkg::B_TX_HOLDING_FREE] = tx_holding_free_i;
    live_w[spis_pkg::B_RX_TRANSFER_END] = rx_transfer_end_i;
    live_w[spis_pkg::B_TX_TRANSFER_END] = tx_transfer_end_i;
    live_w[spis_pkg::B_TMO] = rx_timeout_i; // see [R06]
    live_w[spis_pkg::B_TXEMP] = tx_all_drained_i;
    live_w[spis_pkg::B_TXBE] = tx_dma_buffer_empty_i; // see [R07]
    live_w[spis_pkg::B_RXBF] = rx_dma_buffer_full_i;
    live_w[spis_pkg::B_CTS] = st_r.cts_s2; // see [R11]
    view_w = live_w | st_r.flg; // see [R04]
  end

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.cts_s1 = cts_pin_i;
    st_nxt.cts_s2 = st_r.cts_s1;
    st_nxt.cts_d = st_r.cts_s2;
    // mask update: disable first, enable wins a same-cycle conflict
    if (reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR) begin
      st_nxt.ena = st_r.ena & ~(reg_wdata_i & spis_pkg::MASK_BITS); // see [R02] [R16]
    end
    if (reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET) begin
      st_nxt.ena = st_r.ena | (reg_wdata_i & spis_pkg::MASK_BITS); // see [R01] [R09] [R16]
    end
    // clears first, so that a same-cycle event wins
    if (clr_err_w) begin
      st_nxt.flg[spis_pkg::B_PAR] = 1'b0; // see [R14]
      st_nxt.flg[spis_pkg::B_FRM] = 1'b0;
      st_nxt.flg[spis_pkg::B_OVR] = 1'b0;
      st_nxt.flg[spis_pkg::B_MAN] = 1'b0;
      st_nxt.flg[spis_pkg::B_BRK] = 1'b0;
      st_nxt.flg[spis_pkg::B_ITER] = 1'b0; // see [R08]
    end
    if (clr_non_ack_flag_w) begin
      st_nxt.flg[spis_pkg::B_NON_ACK_FLAG] = 1'b0; // see [R13]
    end
    if (rd_flags_w) begin
      st_nxt.flg[spis_pkg::B_CTS_CHANGE_FLAG] = 1'b0; // see [R12]
    end
    // sticky sets
    if (break_evt_i) st_nxt.flg[spis_pkg::B_BRK] = 1'b1;
    if (overrun_evt_i) st_nxt.flg[spis_pkg::B_OVR] = 1'b1; // see [R15]
    if (framing_evt_i) st_nxt.flg[spis_pkg::B_FRM] = 1'b1; // see [R15]
    if (parity_evt_i) st_nxt.flg[spis_pkg::B_PAR] = 1'b1; // see [R15]
    if (iter_or_underrun_evt_i) st_nxt.flg[spis_pkg::B_ITER] = 1'b1; // see [R08]
    if (non_ack_evt_i) st_nxt.flg[spis_pkg::B_NON_ACK_FLAG] = 1'b1; // see [R13]
    if (manchester_evt_i) st_nxt.flg[spis_pkg::B_MAN] = 1'b1; // see [R10]
    if (st_r.cts_s2 != st_r.cts_d) st_nxt.flg[spis_pkg::B_CTS_CHANGE_FLAG] = 1'b1; // see [R12]
    // read data, valid the cycle after the strobe
    st_nxt.rdata = 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        spis_pkg::OFS_ENA_VIEW: st_nxt.rdata = st_r.ena; // see [R03]
        spis_pkg::OFS_FLAGS: st_nxt.rdata = view_w; // see [R04]
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    // interrupt: flag bit with its mask; mask 20 and 24 both gate manchester
    st_nxt.irq = |((view_w | {7'h0, view_w[spis_pkg::B_MAN], 24'h0} >> 4) & st_r.ena)
      || (view_w[spis_pkg::B_MAN] && st_r.ena[spis_pkg::B_MANLO]); // see [R17]
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.ena <= spis_pkg::ENA_RESET; // see [R03]
      st_r.flg <= spis_pkg::FLAG_RESET;
      st_r.cts_s1 <= 1'b0;
      st_r.cts_s2 <= 1'b0;
      st_r.cts_d <= 1'b0;
      st_r.rdata <= 32'h0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign irq_o = st_r.irq;

  // checks: mask after reset
  a_mask_reset_zero: assert property ( // see [R03]
    @(posedge clk_sys_i) $rose(rst_n_i) |-> st_r.ena == 32'h0)
    else $error("mask not zero after reset");

  // checks: enable register sets mask bits
  a_enable_sets_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R01]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_PAR]
    |=> st_r.ena[spis_pkg::B_PAR])
    else $error("enable write lost");
  a_enable_sets_rx_char_available: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R01]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_RX_CHAR_AVAILABLE]
    |=> st_r.ena[spis_pkg::B_RX_CHAR_AVAILABLE])
    else $error("rx ready enable lost");
  a_enable_sets_non_ack_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R01]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_NON_ACK_FLAG]
    |=> st_r.ena[spis_pkg::B_NON_ACK_FLAG])
    else $error("non_ack_flag enable lost");
  a_enable_sets_cts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_CTS_CHANGE_FLAG]
    |=> st_r.ena[spis_pkg::B_CTS_CHANGE_FLAG])
    else $error("cts change enable lost");
  a_enable_sets_manlo: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_MANLO]
    |=> st_r.ena[spis_pkg::B_MANLO])
    else $error("manchester low enable lost");
  a_enable_sets_manhi: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && reg_wdata_i[spis_pkg::B_MAN]
    |=> st_r.ena[spis_pkg::B_MAN])
    else $error("manchester high enable lost");

  // checks: disable register clears mask bits
  a_disable_clears_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R02]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_PAR]
    |=> !st_r.ena[spis_pkg::B_PAR])
    else $error("disable write lost");
  a_disable_rx_char_available: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R02]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_RX_CHAR_AVAILABLE]
    |=> !st_r.ena[spis_pkg::B_RX_CHAR_AVAILABLE])
    else $error("rx ready disable lost");
  a_disable_non_ack_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R02]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_NON_ACK_FLAG]
    |=> !st_r.ena[spis_pkg::B_NON_ACK_FLAG])
    else $error("non_ack_flag disable lost");
  a_disable_cts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_CTS_CHANGE_FLAG]
    |=> !st_r.ena[spis_pkg::B_CTS_CHANGE_FLAG])
    else $error("cts change disable lost");
  a_disable_manlo: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_MANLO]
    |=> !st_r.ena[spis_pkg::B_MANLO])
    else $error("manchester low disable lost");
  a_disable_manhi: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && reg_wdata_i[spis_pkg::B_MAN]
    |=> !st_r.ena[spis_pkg::B_MAN])
    else $error("manchester high disable lost");

  // checks: zero bits and other writes leave the mask alone
  a_zero_write_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R16]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_SET && !reg_wdata_i[spis_pkg::B_OVR]
    |=> st_r.ena[spis_pkg::B_OVR] == $past(st_r.ena[spis_pkg::B_OVR]))
    else $error("zero write changed mask");
  a_zero_clear_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R16]
    reg_wr_i && reg_addr_i == spis_pkg::OFS_ENA_CLR && !reg_wdata_i[spis_pkg::B_OVR]
    |=> st_r.ena[spis_pkg::B_OVR] == $past(st_r.ena[spis_pkg::B_OVR]))
    else $error("zero disable changed mask");
  a_mask_only_by_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R16]
    !(reg_wr_i && (reg_addr_i == spis_pkg::OFS_ENA_SET || reg_addr_i == spis_pkg::OFS_ENA_CLR))
    |=> $stable(st_r.ena))
    else $error("mask changed without write");
  a_mask_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R07]
    (st_r.ena & ~spis_pkg::MASK_BITS) == 32'h0)
    else $error("unused mask bit set");

  // checks: error events set their flags
  a_break_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R05]
    break_evt_i
    |=> st_r.flg[spis_pkg::B_BRK])
    else $error("break flag missed");
  a_overrun_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    overrun_evt_i
    |=> st_r.flg[spis_pkg::B_OVR])
    else $error("overrun flag missed");
  a_framing_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    framing_evt_i
    |=> st_r.flg[spis_pkg::B_FRM])
    else $error("framing flag missed");
  a_parity_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    parity_evt_i
    |=> st_r.flg[spis_pkg::B_PAR])
    else $error("parity flag missed");
  a_iter_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R08]
    iter_or_underrun_evt_i
    |=> st_r.flg[spis_pkg::B_ITER])
    else $error("iteration flag missed");
  a_non_ack_flag_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R13]
    non_ack_evt_i
    |=> st_r.flg[spis_pkg::B_NON_ACK_FLAG])
    else $error("non_ack_flag flag missed");
  a_manchester_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R10]
    manchester_evt_i
    |=> st_r.flg[spis_pkg::B_MAN])
    else $error("manchester flag missed");
  a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    clr_err_w && parity_evt_i
    |=> st_r.flg[spis_pkg::B_PAR])
    else $error("parity lost to clear");

  // checks: sticky flags hold until their clear command
  a_overrun_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    overrun_evt_i ##1 !clr_err_w [*3]
    |=> st_r.flg[spis_pkg::B_OVR])
    else $error("overrun not sticky");
  a_overrun_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    st_r.flg[spis_pkg::B_OVR] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_OVR])
    else $error("overrun flag lost");
  a_framing_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    st_r.flg[spis_pkg::B_FRM] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_FRM])
    else $error("framing flag lost");
  a_parity_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R15]
    st_r.flg[spis_pkg::B_PAR] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_PAR])
    else $error("parity flag lost");
  a_break_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R14]
    st_r.flg[spis_pkg::B_BRK] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_BRK])
    else $error("break flag lost");
  a_manchester_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R10]
    st_r.flg[spis_pkg::B_MAN] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_MAN])
    else $error("manchester flag lost");
  a_iter_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R08]
    st_r.flg[spis_pkg::B_ITER] && !clr_err_w
    |=> st_r.flg[spis_pkg::B_ITER])
    else $error("iteration flag lost");
  a_non_ack_flag_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R13]
    st_r.flg[spis_pkg::B_NON_ACK_FLAG] && !clr_non_ack_flag_w
    |=> st_r.flg[spis_pkg::B_NON_ACK_FLAG])
    else $error("non_ack_flag flag lost");

  // checks: clear commands
  a_clear_errors: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R14]
    clr_err_w && !parity_evt_i && !manchester_evt_i
    |=> !st_r.flg[spis_pkg::B_PAR] && !st_r.flg[spis_pkg::B_MAN])
    else $error("clear errors failed");
  a_clear_errors_rest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R14]
    clr_err_w && !overrun_evt_i && !framing_evt_i && !break_evt_i
    |=> !st_r.flg[spis_pkg::B_OVR] && !st_r.flg[spis_pkg::B_FRM] && !st_r.flg[spis_pkg::B_BRK])
    else $error("clear errors left a flag");
  a_clear_keeps_non_ack_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R14]
    clr_err_w && !clr_non_ack_flag_w && st_r.flg[spis_pkg::B_NON_ACK_FLAG]
    |=> st_r.flg[spis_pkg::B_NON_ACK_FLAG])
    else $error("clear errors hit non_ack_flag");
  a_clear_non_ack_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R13]
    clr_non_ack_flag_w && !non_ack_evt_i
    |=> !st_r.flg[spis_pkg::B_NON_ACK_FLAG])
    else $error("clear non_ack_flag failed");
  a_clear_non_ack_flag_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R13]
    clr_non_ack_flag_w && !clr_err_w && st_r.flg[spis_pkg::B_PAR]
    |=> st_r.flg[spis_pkg::B_PAR])
    else $error("clear non_ack_flag hit parity");

  // checks: cts image and change flag
  a_cts_change_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R12]
    st_r.cts_s2 != st_r.cts_d
    |=> st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG])
    else $error("cts change missed");
  a_cts_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R12]
    rd_flags_w && st_r.cts_s2 == st_r.cts_d
    |=> !st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG])
    else $error("cts change not cleared by read");
  a_cts_change_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R12]
    st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG] && !rd_flags_w
    |=> st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG])
    else $error("cts change flag lost");
  a_cts_image: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R11]
    rd_flags_w
    |=> reg_rdata_o[spis_pkg::B_CTS] == $past(st_r.cts_s2))
    else $error("cts image wrong");

  // checks: read data
  a_rdata_idle_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R03]
    !reg_rd_i
    |=> reg_rdata_o == 32'h0)
    else $error("read data without read");
  a_mask_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R03]
    reg_rd_i && reg_addr_i == spis_pkg::OFS_ENA_VIEW
    |=> reg_rdata_o == $past(st_r.ena))
    else $error("mask read wrong");
  a_set_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R01]
    reg_rd_i && reg_addr_i == spis_pkg::OFS_ENA_SET
    |=> reg_rdata_o == 32'h0)
    else $error("enable register readable");
  a_clr_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R02]
    reg_rd_i && reg_addr_i == spis_pkg::OFS_ENA_CLR
    |=> reg_rdata_o == 32'h0)
    else $error("disable register readable");
  a_flags_read_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R04]
    rd_flags_w
    |=> (reg_rdata_o & $past(st_r.flg)) == $past(st_r.flg))
    else $error("sticky flag missing from read");
  a_flags_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R07]
    rd_flags_w
    |=> (reg_rdata_o & 32'hfe77_c000) == 32'h0)
    else $error("unused flag bit set");
  a_live_tx_free: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R05]
    rd_flags_w
    |=> reg_rdata_o[spis_pkg::B_TX_HOLDING_FREE] == $past(tx_holding_free_i))
    else $error("tx ready level wrong");
  a_live_timeout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R06]
    rd_flags_w
    |=> reg_rdata_o[spis_pkg::B_TMO] == $past(rx_timeout_i))
    else $error("timeout level wrong");
  a_live_rx_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R07]
    rd_flags_w
    |=> reg_rdata_o[spis_pkg::B_RXBF] == $past(rx_dma_buffer_full_i))
    else $error("rx buffer full level wrong");

  // checks: interrupt output
  a_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R17]
    st_r.flg[spis_pkg::B_NON_ACK_FLAG] && st_r.ena[spis_pkg::B_NON_ACK_FLAG]
    |=> irq_o)
    else $error("irq not raised");
  a_irq_live: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R17]
    rx_char_available_i && st_r.ena[spis_pkg::B_RX_CHAR_AVAILABLE]
    |=> irq_o)
    else $error("irq missed live source");
  a_irq_cts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R17]
    st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG] && st_r.ena[spis_pkg::B_CTS_CHANGE_FLAG]
    |=> irq_o)
    else $error("irq missed cts change");
  a_irq_man_lo: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    st_r.flg[spis_pkg::B_MAN] && st_r.ena[spis_pkg::B_MANLO]
    |=> irq_o)
    else $error("irq missed manchester low enable");
  a_irq_man_hi: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R09]
    st_r.flg[spis_pkg::B_MAN] && st_r.ena[spis_pkg::B_MAN]
    |=> irq_o)
    else $error("irq missed manchester high enable");
  a_irq_low_masked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // see [R17]
    st_r.ena == 32'h0
    |=> !irq_o)
    else $error("irq high with empty mask");

  // main scenarios reached
  c_irq_rise: cover property (@(posedge clk_sys_i) $rose(irq_o));
  c_clear_errors: cover property (@(posedge clk_sys_i) clr_err_w && st_r.flg[spis_pkg::B_OVR]);
  c_cts_read: cover property (@(posedge clk_sys_i) rd_flags_w && st_r.flg[spis_pkg::B_CTS_CHANGE_FLAG]);
  c_mask_write: cover property (@(posedge clk_sys_i) reg_wr_i
    && reg_addr_i == spis_pkg::OFS_ENA_SET);
  c_manchester_irq: cover property (@(posedge clk_sys_i) st_r.flg[spis_pkg::B_MAN] && irq_o);

endmodule : spis_irq_status

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  // design inputs and outputs
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [7:0] lv = 8'h00; // live levels
  logic [6:0] ev = 7'h00; // error event pulses
  logic cts_pin_i = 1'b0;
  logic irq_o;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int lpos[8] = '{0, 1, 3, 4, 8, 9, 11, 12};
  int epos[7] = '{2, 5, 6, 7, 10, 13, 24};
  logic [31:0] acc;
  // clock
  always #5 clk_sys_i = ~clk_sys_i;
  // block under test
  spis_irq_status spis_irq_status_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_char_available_i(lv[0]), .tx_holding_free_i(lv[1]),
    .rx_transfer_end_i(lv[2]), .tx_transfer_end_i(lv[3]), .rx_timeout_i(lv[4]),
    .tx_all_drained_i(lv[5]), .tx_dma_buffer_empty_i(lv[6]), .rx_dma_buffer_full_i(lv[7]),
    .break_evt_i(ev[0]), .overrun_evt_i(ev[1]), .framing_evt_i(ev[2]), .parity_evt_i(ev[3]),
    .iter_or_underrun_evt_i(ev[4]), .non_ack_evt_i(ev[5]), .manchester_evt_i(ev[6]),
    .cts_pin_i(cts_pin_i), .irq_o(irq_o)
  );
  // verdict and end of run
  task automatic results;
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // one-cycle read, data checked in the following cycle
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(what, exp, reg_rdata_o);
  endtask : rd
  // one-cycle pulse on one event input
  task automatic pulse(input int i);
    @(posedge clk_sys_i);
    ev <= 7'(1 << i);
    @(posedge clk_sys_i);
    ev <= 7'h00;
  endtask : pulse
  // interrupt level after a settling delay
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, irq_o});
  endtask : chk_irq
  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd("mask", spis_pkg::OFS_ENA_VIEW, spis_pkg::ENA_RESET);
    rd("flags", spis_pkg::OFS_FLAGS, spis_pkg::FLAG_RESET);
    wr(8'h40, 32'hffff_ffff);
    rd("unmapped", 8'h40, 32'h0000_0000);
    rd("mask", spis_pkg::OFS_ENA_VIEW, 32'h0000_0000);
    wr(spis_pkg::OFS_ENA_SET, 32'hffff_ffff);
    rd("mask", spis_pkg::OFS_ENA_VIEW, spis_pkg::MASK_BITS);
    wr(spis_pkg::OFS_ENA_CLR, 32'h0000_0001);
    wr(spis_pkg::OFS_ENA_SET, 32'h0000_0000);
    rd("mask", spis_pkg::OFS_ENA_VIEW, spis_pkg::MASK_BITS & ~32'h1);
    wr(spis_pkg::OFS_ENA_CLR, 32'hffff_ffff);
    rd("mask", spis_pkg::OFS_ENA_VIEW, 32'h0000_0000);
    // each live level lands on its own bit
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      lv <= 8'(1 << i);
      rd("live flag", spis_pkg::OFS_FLAGS, 32'h1 << lpos[i]);
    end
    @(posedge clk_sys_i);
    lv <= 8'h00;
    // events accumulate as sticky flags
    acc = 32'h0;
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      acc = acc | (32'h1 << epos[i]);
      rd("sticky flag", spis_pkg::OFS_FLAGS, acc);
    end
    wr(spis_pkg::OFS_CTRL, 32'h1 << spis_pkg::CMD_CLR_ERR_BIT);
    rd("after clear errors", spis_pkg::OFS_FLAGS, 32'h0000_2000);
    wr(spis_pkg::OFS_CTRL, 32'h1 << spis_pkg::CMD_CLR_NON_ACK_FLAG_BIT);
    rd("after clear non_ack_flag", spis_pkg::OFS_FLAGS, 32'h0000_0000);
    // interrupt from manchester and non_ack_flag sources
    wr(spis_pkg::OFS_ENA_SET, 32'h0010_0000);
    pulse(6);
    chk_irq(1'b1);
    wr(spis_pkg::OFS_CTRL, 32'h1 << spis_pkg::CMD_CLR_ERR_BIT);
    chk_irq(1'b0);
    wr(spis_pkg::OFS_ENA_SET, 32'h0000_2000);
    pulse(5);
    chk_irq(1'b1);
    wr(spis_pkg::OFS_ENA_CLR, 32'h0000_2000);
    chk_irq(1'b0);
    // cts image and change flag cleared by reading
    @(posedge clk_sys_i);
    cts_pin_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd("cts flags", spis_pkg::OFS_FLAGS, 32'h0088_2000);
    rd("cts flags", spis_pkg::OFS_FLAGS, 32'h0080_2000);
    results();
  end
endmodule : tb
